// [hdl/nlid_consts.vh]
// Constants for the nibble processor load-instruction decoder
`ifndef NLID_CONSTS_VH
`define NLID_CONSTS_VH

// Instruction set shape
`define NLID_NUM_TYPES      52
`define NLID_NUM_CLASSES    6
`define NLID_CLASS_XFER     3'h0
`define NLID_CLASS_NONE     3'h7

// Opcode encodings, upper nibble and fixed codes
`define NLID_OP_IMM_HI      4'h4
`define NLID_OP_PORT_HI     5'h02
`define NLID_OP_PORT_TEST   1'h1
`define NLID_OP_MEM         8'h04
`define NLID_OP_STATUS_MEM  8'h05
`define NLID_OP_LOW         8'h06
`define NLID_OP_HIGH        8'h07
`define NLID_OP_MEM_TEST    8'h87

// Internal bus source codes
`define NLID_SRC_PORT       3'h0
`define NLID_SRC_MEM        3'h1
`define NLID_SRC_LOW        3'h2
`define NLID_SRC_HIGH       3'h3
`define NLID_SRC_IMM        3'h4

// Operand field selects for branch target assembly
`define NLID_FLD_OPCODE     2'h0
`define NLID_FLD_AP_HI      2'h1
`define NLID_FLD_AP_MID     2'h2
`define NLID_FLD_AP_LO      2'h3

// Status register bit positions
`define NLID_ST_CARRY       0
`define NLID_ST_ZERO        1

// Register offsets
`define NLID_REG_ACC        4'h0
`define NLID_REG_STATUS     4'h1
`define NLID_REG_LOW        4'h2
`define NLID_REG_HIGH       4'h3
`define NLID_REG_ALT        4'h4
`define NLID_REG_CTRL       4'h5
`define NLID_REG_FLAGS      4'h6
`define NLID_REG_LAST_OP    4'h7
`define NLID_REG_LOAD_CNT   4'h8
`define NLID_REG_BR_LOW     4'h9
`define NLID_REG_BR_HIGH    4'hA

// Control and flag bits
`define NLID_CTRL_USE_ALT   0
`define NLID_FLAGS_ALT_VAL  0

// Reset values
`define NLID_RST_NIBBLE     4'h0
`define NLID_RST_BYTE       8'h00
`define NLID_RST_STATUS     2'h0

`endif

// [hdl/nlid_nib_reg.v]
// Loadable register with a constant reset value
module nlid_nib_reg #(
  parameter       W   = 4,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         clk_sys_in,
  input  wire         rst_in,
  input  wire         load_in,
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      q_out <= RST;
    end else if (load_in) begin
      q_out <= d_in;
    end
  end

endmodule // nlid_nib_reg

// [hdl/nlid_opdec.v]
// Opcode decoder for the load-type transfer group
`include "nlid_consts.vh"

module nlid_opdec (
  input  wire [7:0] op_in,
  output reg        hit_out,
  output reg  [2:0] src_out,
  output reg        to_acc_out,
  output reg        to_status_out,
  output reg        test_zero_out,
  output wire [2:0] class_out,
  output wire [2:0] port_sel_out,
  output wire [3:0] imm_out
);

  assign port_sel_out = op_in[2:0];
  assign imm_out      = op_in[3:0];
  assign class_out    = hit_out ? `NLID_CLASS_XFER : `NLID_CLASS_NONE; // (RQ1)

  always @* begin
    hit_out       = 1'b1;
    src_out       = `NLID_SRC_PORT;
    to_acc_out    = 1'b1;
    to_status_out = 1'b0;
    test_zero_out = 1'b0;
    if (op_in[7:4] == `NLID_OP_IMM_HI) begin
      src_out = `NLID_SRC_IMM; // (RQ9)
    end else if (op_in[7:3] == `NLID_OP_PORT_HI) begin
      src_out = `NLID_SRC_PORT; // (RQ2)
      test_zero_out = (op_in[3] == `NLID_OP_PORT_TEST); // (RQ3)
    end else if (op_in[7:3] == (`NLID_OP_PORT_HI | 5'h03)) begin
      src_out = `NLID_SRC_PORT;
      test_zero_out = 1'b1; // (RQ3)
    end else begin
      case (op_in)
        `NLID_OP_MEM: begin
          src_out = `NLID_SRC_MEM; // (RQ4)
        end
        `NLID_OP_MEM_TEST: begin
          src_out       = `NLID_SRC_MEM; // (RQ5)
          test_zero_out = 1'b1;
        end
        `NLID_OP_STATUS_MEM: begin
          src_out       = `NLID_SRC_MEM; // (RQ6)
          to_acc_out    = 1'b0;
          to_status_out = 1'b1;
        end
        `NLID_OP_LOW: begin
          src_out = `NLID_SRC_LOW; // (RQ7)
        end
        `NLID_OP_HIGH: begin
          src_out = `NLID_SRC_HIGH; // (RQ8)
        end
        default: begin
          hit_out    = 1'b0;
          to_acc_out = 1'b0;
        end
      endcase
    end
  end

endmodule // nlid_opdec

// [hdl/nlid_core.v]
// Load-instruction decode and execute datapath with register port
`include "nlid_consts.vh"

// Functional notes
// (RQ1) Decoder knows 52 types in 6 classes; load transfers are executed here.
// (RQ2) Port-register load copies selected port or input into accumulator, flags kept.
// (RQ3) Port-register load and test copies, then updates zero flag, carry kept.
// (RQ4) Memory load copies addressed nibble into accumulator, flags kept.
// (RQ5) Memory load and test copies nibble, updates zero flag, carry kept.
// (RQ6) Status load from memory writes zero and carry straight from memory.
// (RQ7) Low pointer copied into accumulator in one cycle, flags kept.
// (RQ8) High pointer copied into accumulator in one cycle, flags kept.
// (RQ9) Upper bits 0100 load low four bits as immediate into accumulator.
// (RQ10) Branch target is three 4-bit fields joined high, middle, low.
// (RQ11) Bit-manipulation bit position comes from a dedicated instruction field.
// (RQ12) Memory address comes from high and low pointers, or alternate pointer.
// (RQ13) All transfers pass over one shared 4-bit internal bus.
// (RQ14) Tested zero flag is one exactly when loaded nibble is zero.
// (RQ15) Every load instruction leaves alternate-pointer valid flag cleared; a FLAGS register write in the same cycle wins over the clear.
module nlid_core (
  input  wire        clk_sys_in,
  input  wire        rst_in,
  input  wire [7:0]  instr_in,
  input  wire        instr_valid_in,
  input  wire [1:0]  field_sel_in,
  input  wire [3:0]  port_data_in,
  input  wire [3:0]  mem_data_in,
  input  wire [3:0]  reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [7:0]  reg_rdata_out,
  output wire [2:0]  port_sel_out,
  output wire [7:0]  mem_addr_out,
  output wire [3:0]  acc_out,
  output wire        zero_flag_out,
  output wire        carry_flag_out,
  output wire        alt_valid_out,
  output wire [11:0] branch_target_address_out,
  output reg  [1:0]  bit_select_out,
  output reg  [3:0]  bit_mask_out,
  output reg  [2:0]  instr_class_out,
  output reg         load_done_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  wire       dec_hit;
  wire [2:0] dec_src;
  wire       dec_to_acc;
  wire       dec_to_status;
  wire       dec_test_zero;
  wire [2:0] dec_class;
  wire [3:0] dec_imm;

  wire       opcode_cycle;
  wire       exec;
  reg  [3:0] internal_bus;
  wire       bus_zero;

  wire [3:0] accumulator_nibble;
  wire [3:0] low_pointer_register;
  wire [3:0] high_pointer_register;
  wire [3:0] alt_pointer_register;
  reg  [1:0] status_flags_register;
  reg        alt_pointer_valid_flag;
  reg        use_alt_pointer;
  reg  [7:0] last_opcode;
  reg  [7:0] load_count;

  wire       acc_load;
  reg  [3:0] next_acc;
  wire       wr_acc;
  wire       wr_low;
  wire       wr_high;
  wire       wr_alt;
  wire       wr_status;
  wire       wr_ctrl;
  wire       wr_flags;
  reg  [1:0] next_status;

  wire [2:0] field_load;
  wire [3:0] target_hi;
  wire [3:0] target_mid;
  wire [3:0] target_lo;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  assign opcode_cycle = instr_valid_in && (field_sel_in == `NLID_FLD_OPCODE);

  nlid_opdec u_opdec (
    .op_in         (instr_in),
    .hit_out       (dec_hit),
    .src_out       (dec_src),
    .to_acc_out    (dec_to_acc),
    .to_status_out (dec_to_status),
    .test_zero_out (dec_test_zero),
    .class_out     (dec_class),
    .port_sel_out  (port_sel_out),
    .imm_out       (dec_imm)
  );

  assign exec = opcode_cycle && dec_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Shared 4-bit internal bus

  always @* begin
    case (dec_src)
      `NLID_SRC_PORT: internal_bus = port_data_in; // (RQ13)
      `NLID_SRC_MEM:  internal_bus = mem_data_in; // (RQ13)
      `NLID_SRC_LOW:  internal_bus = low_pointer_register; // (RQ13)
      `NLID_SRC_HIGH: internal_bus = high_pointer_register; // (RQ13)
      `NLID_SRC_IMM:  internal_bus = dec_imm; // (RQ13)
      default:        internal_bus = `NLID_RST_NIBBLE;
    endcase
  end

  assign bus_zero = (internal_bus == `NLID_RST_NIBBLE); // (RQ14)

  // Pointer pair forms the row and column of the data memory address
  assign mem_addr_out = use_alt_pointer ? {`NLID_RST_NIBBLE, alt_pointer_register}
                                        : {high_pointer_register, low_pointer_register}; // (RQ12)

  ////////////////////////////////////////////////////////////////////////////
  // Register port write decode

  assign wr_acc    = reg_wr_in && (reg_addr_in == `NLID_REG_ACC);
  assign wr_status = reg_wr_in && (reg_addr_in == `NLID_REG_STATUS);
  assign wr_low    = reg_wr_in && (reg_addr_in == `NLID_REG_LOW);
  assign wr_high   = reg_wr_in && (reg_addr_in == `NLID_REG_HIGH);
  assign wr_alt    = reg_wr_in && (reg_addr_in == `NLID_REG_ALT);
  assign wr_ctrl   = reg_wr_in && (reg_addr_in == `NLID_REG_CTRL);
  assign wr_flags  = reg_wr_in && (reg_addr_in == `NLID_REG_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and pointers

  // An executing load beats a software write in the same cycle
  assign acc_load = (exec && dec_to_acc) || wr_acc;

  always @* begin
    if (exec && dec_to_acc) begin
      next_acc = internal_bus; // (RQ2) (RQ4) (RQ7) (RQ8) (RQ9)
    end else begin
      next_acc = reg_wdata_in[3:0];
    end
  end

  nlid_nib_reg #(.W(4), .RST(`NLID_RST_NIBBLE)) u_acc (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (acc_load),
    .d_in       (next_acc),
    .q_out      (accumulator_nibble)
  );

  nlid_nib_reg #(.W(4), .RST(`NLID_RST_NIBBLE)) u_low (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (wr_low),
    .d_in       (reg_wdata_in[3:0]),
    .q_out      (low_pointer_register)
  );

  nlid_nib_reg #(.W(4), .RST(`NLID_RST_NIBBLE)) u_high (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (wr_high),
    .d_in       (reg_wdata_in[3:0]),
    .q_out      (high_pointer_register)
  );

  nlid_nib_reg #(.W(4), .RST(`NLID_RST_NIBBLE)) u_alt (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (wr_alt),
    .d_in       (reg_wdata_in[3:0]),
    .q_out      (alt_pointer_register)
  );

  assign acc_out = accumulator_nibble;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  always @* begin
    next_status = status_flags_register;
    if (wr_status) begin
      next_status = reg_wdata_in[1:0];
    end
    if (exec && dec_to_status) begin
      next_status[`NLID_ST_ZERO]  = internal_bus[`NLID_ST_ZERO]; // (RQ6)
      next_status[`NLID_ST_CARRY] = internal_bus[`NLID_ST_CARRY]; // (RQ6)
    end else if (exec && dec_test_zero) begin
      next_status[`NLID_ST_ZERO] = bus_zero; // (RQ3) (RQ5) (RQ14)
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      status_flags_register <= `NLID_RST_STATUS;
    end else begin
      status_flags_register <= next_status;
    end
  end

  assign zero_flag_out  = status_flags_register[`NLID_ST_ZERO];
  assign carry_flag_out = status_flags_register[`NLID_ST_CARRY];

  ////////////////////////////////////////////////////////////////////////////
  // Control, alternate-pointer flag, history

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      use_alt_pointer        <= 1'b0;
      alt_pointer_valid_flag <= 1'b0;
      last_opcode            <= `NLID_RST_BYTE;
      load_count             <= `NLID_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        use_alt_pointer <= reg_wdata_in[`NLID_CTRL_USE_ALT];
      end
      // Software set wins over a load's clear in the same cycle
      if (wr_flags) begin
        alt_pointer_valid_flag <= reg_wdata_in[`NLID_FLAGS_ALT_VAL];
      end else if (exec) begin
        alt_pointer_valid_flag <= 1'b0; // (RQ15)
      end
      if (exec) begin
        last_opcode <= instr_in;
        load_count  <= load_count + 8'h01;
      end
    end
  end

  assign alt_valid_out = alt_pointer_valid_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Branch target fields and bit selector

  assign field_load[0] = instr_valid_in && (field_sel_in == `NLID_FLD_AP_HI);
  assign field_load[1] = instr_valid_in && (field_sel_in == `NLID_FLD_AP_MID);
  assign field_load[2] = instr_valid_in && (field_sel_in == `NLID_FLD_AP_LO);

  nlid_nib_reg #(.W(4), .RST(`NLID_RST_NIBBLE)) u_ap_hi (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (field_load[0]),
    .d_in       (instr_in[3:0]),
    .q_out      (target_hi)
  );

  nlid_nib_reg #(.W(4), .RST(`NLID_RST_NIBBLE)) u_ap_mid (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (field_load[1]),
    .d_in       (instr_in[3:0]),
    .q_out      (target_mid)
  );

  nlid_nib_reg #(.W(4), .RST(`NLID_RST_NIBBLE)) u_ap_lo (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (field_load[2]),
    .d_in       (instr_in[3:0]),
    .q_out      (target_lo)
  );

  assign branch_target_address_out = {target_hi, target_mid, target_lo}; // (RQ10)

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bit_select_out  <= 2'h0;
      bit_mask_out    <= 4'h1;
      instr_class_out <= `NLID_CLASS_NONE;
      load_done_out   <= 1'b0;
    end else begin
      load_done_out <= exec;
      if (opcode_cycle) begin
        bit_select_out  <= instr_in[1:0]; // (RQ11)
        bit_mask_out    <= 4'h1 << instr_in[1:0]; // (RQ11)
        instr_class_out <= dec_class; // (RQ1)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port read, data one cycle after the strobe

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= `NLID_RST_BYTE;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `NLID_REG_ACC:      reg_rdata_out <= {4'h0, accumulator_nibble};
        `NLID_REG_STATUS:   reg_rdata_out <= {6'h00, status_flags_register};
        `NLID_REG_LOW:      reg_rdata_out <= {4'h0, low_pointer_register};
        `NLID_REG_HIGH:     reg_rdata_out <= {4'h0, high_pointer_register};
        `NLID_REG_ALT:      reg_rdata_out <= {4'h0, alt_pointer_register};
        `NLID_REG_CTRL:     reg_rdata_out <= {7'h00, use_alt_pointer};
        `NLID_REG_FLAGS:    reg_rdata_out <= {7'h00, alt_pointer_valid_flag};
        `NLID_REG_LAST_OP:  reg_rdata_out <= last_opcode;
        `NLID_REG_LOAD_CNT: reg_rdata_out <= load_count;
        `NLID_REG_BR_LOW:   reg_rdata_out <= {target_mid, target_lo};
        `NLID_REG_BR_HIGH:  reg_rdata_out <= {4'h0, target_hi};
        default:            reg_rdata_out <= `NLID_RST_BYTE;
      endcase
    end else begin
      reg_rdata_out <= `NLID_RST_BYTE;
    end
  end

endmodule // nlid_core

// [test/nlid_env_model.sv]
// Data memory and port register model facing the decoder
module nlid_env_model (
  input  wire [7:0] mem_addr_in,
  input  wire [2:0] port_sel_in,
  output wire [3:0] mem_data_out,
  output wire [3:0] port_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contents are a fixed function of the address so the bench can predict them
  assign mem_data_out  = mem_addr_in[7:4] ^ mem_addr_in[3:0];
  assign port_data_out = 4'h7 - {1'b0, port_sel_in};
endmodule // nlid_env_model

// [test/nlid_core_monitor.sv]
// Port-level assertions for the load-instruction decoder
module nlid_core_monitor (
  input wire        clk_sys_in,
  input wire        rst_in,
  input wire [7:0]  instr_in,
  input wire        instr_valid_in,
  input wire [1:0]  field_sel_in,
  input wire [3:0]  port_data_in,
  input wire [3:0]  mem_data_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [7:0]  reg_rdata_out,
  input wire [3:0]  acc_out,
  input wire        zero_flag_out,
  input wire        carry_flag_out,
  input wire        alt_valid_out,
  input wire [11:0] branch_target_address_out,
  input wire [3:0]  bit_mask_out,
  input wire [2:0]  instr_class_out,
  input wire        load_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Register writes excluded: they may legally race a load
  wire op    = instr_valid_in && field_sel_in == 2'h0 && !reg_wr_in;
  wire is_ld = instr_in[7:4] == 4'h4 || instr_in[7:4] == 4'h1 || instr_in == 8'h87 || instr_in[7:2] == 6'h01;
  wire [1:0] zc = {zero_flag_out, carry_flag_out};
  ////////////////////////////////////////////////////////////////////////////////
  property p_imm;
    op && instr_in[7:4] == 4'h4 |=> acc_out == $past(instr_in[3:0]) && $stable(zc);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate load wrong");
  property p_port;
    op && instr_in[7:3] == 5'h02 |=> acc_out == $past(port_data_in) && $stable(zc);
  endproperty
  a_port: assert property (p_port) else $error("port load wrong");
  property p_ptest;
    op && instr_in[7:3] == 5'h03 |=> acc_out == $past(port_data_in) && $stable(carry_flag_out)
      && zero_flag_out == ($past(port_data_in) == 4'h0);
  endproperty
  a_ptest: assert property (p_ptest) else $error("port test load wrong");
  property p_mem;
    op && instr_in == 8'h04 |=> acc_out == $past(mem_data_in) && $stable(zc);
  endproperty
  a_mem: assert property (p_mem) else $error("memory load wrong");
  property p_mtest;
    op && instr_in == 8'h87 |=> acc_out == $past(mem_data_in) && $stable(carry_flag_out)
      && zero_flag_out == ($past(mem_data_in) == 4'h0);
  endproperty
  a_mtest: assert property (p_mtest) else $error("memory test load wrong");
  property p_status;
    op && instr_in == 8'h05 |=> zc == $past(mem_data_in[1:0]) && $stable(acc_out);
  endproperty
  a_status: assert property (p_status) else $error("status load wrong");
  property p_done;
    op && is_ld |=> load_done_out && !alt_valid_out && instr_class_out == 3'h0;
  endproperty
  a_done: assert property (p_done) else $error("load completion wrong");
  property p_nl;
    op && !is_ld |=> !load_done_out && instr_class_out == 3'h7 && $stable(acc_out);
  endproperty
  a_nl: assert property (p_nl) else $error("non-load opcode acted");
  property p_rd;
    !reg_rd_in |=> reg_rdata_out == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("read data outside its cycle");
  property p_br;
    instr_valid_in && field_sel_in == 2'h1 |=> branch_target_address_out[11:8] == $past(instr_in[3:0]);
  endproperty
  a_br: assert property (p_br) else $error("branch high field wrong");
  property p_bit;
    instr_valid_in && field_sel_in == 2'h0 |=> bit_mask_out == (4'h1 << $past(instr_in[1:0]));
  endproperty
  a_bit: assert property (p_bit) else $error("bit mask wrong");
endmodule // nlid_core_monitor

// [test/tb.sv]
// Self-checking bench for the load-instruction decoder
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  instr_in = 8'h00;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        instr_valid_in = 1'b0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [1:0]  field_sel_in = 2'h0;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [7:0]  v;
  wire  [3:0]  port_data_in, mem_data_in, acc_out, bit_mask_out;
  wire  [7:0]  mem_addr_out, reg_rdata_out;
  wire  [2:0]  port_sel_out, instr_class_out;
  wire         zero_flag_out, carry_flag_out, alt_valid_out, load_done_out;
  wire  [11:0] branch_target_address_out;
  wire  [1:0]  bit_select_out;
  int          err_count = 0;
  int          n_checks = 0;
  int          i;
  nlid_core i_nlid_core (.clk_sys_in, .rst_in, .instr_in, .instr_valid_in, .field_sel_in, .port_data_in,
    .mem_data_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .port_sel_out,
    .mem_addr_out, .acc_out, .zero_flag_out, .carry_flag_out, .alt_valid_out, .branch_target_address_out,
    .bit_select_out, .bit_mask_out, .instr_class_out, .load_done_out);
  nlid_env_model i_nlid_env_model (.mem_addr_in(mem_addr_out), .port_sel_in(port_sel_out),
    .mem_data_out(mem_data_in), .port_data_out(port_data_in));
  initial forever #2 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    // Let the write settle before anyone looks at the register it hit
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic ex(input logic [7:0] op, input logic [1:0] sel = 2'h0);
    @(posedge clk_sys_in);
    instr_in <= op;
    field_sel_in <= sel;
    instr_valid_in <= 1'b1;
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b0;
    #1;
  endtask
  task automatic exa(input logic [7:0] op, input logic [3:0] exp);
    ex(op);
    chk(acc_out, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    err_count++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    chk(instr_class_out, 3'h7);
    // Flags set first so untouched flags stay visible
    wr(4'h1, 8'h03);
    for (i = 0; i < 16; i++) begin
      exa(8'h40 | i[7:0], i[3:0]);
      chk({zero_flag_out, carry_flag_out, instr_class_out}, 5'h18);
    end
    $display("immediate test done");
    for (i = 0; i < 8; i++) begin
      exa(8'h10 | i[7:0], 4'h7 - i[3:0]);
      chk(port_sel_out, i[2:0]);
      exa(8'h18 | i[7:0], 4'h7 - i[3:0]);
      chk({zero_flag_out, carry_flag_out}, {i == 7, 1'b1});
    end
    $display("port test done");
    wr(4'h2, 8'h05);
    wr(4'h3, 8'h09);
    exa(8'h06, 4'h5);
    exa(8'h07, 4'h9);
    chk(mem_addr_out, 8'h95);
    exa(8'h04, 4'hC);
    exa(8'h87, 4'hC);
    chk({zero_flag_out, carry_flag_out}, 2'h1);
    wr(4'h2, 8'h09);
    exa(8'h87, 4'h0);
    chk({zero_flag_out, carry_flag_out}, 2'h3);
    exa(8'h05, 4'h0);
    chk({zero_flag_out, carry_flag_out}, 2'h0);
    wr(4'h2, 8'h0B);
    exa(8'h05, 4'h0);
    chk({zero_flag_out, carry_flag_out}, 2'h2);
    $display("memory test done");
    wr(4'h5, 8'h01);
    wr(4'h4, 8'h06);
    wr(4'h6, 8'h01);
    chk(alt_valid_out, 1'b1);
    exa(8'h04, 4'h6);
    chk(alt_valid_out, 1'b0);
    rdc(4'h6, 8'h00);
    rdc(4'h0, 8'h06);
    $display("alternate pointer test done");
    rd(4'h8, v);
    @(posedge clk_sys_in);
    field_sel_in <= 2'h0;
    instr_valid_in <= 1'b1;
    for (i = 0; i < 3; i++) begin
      instr_in <= 8'h41 + i[7:0];
      @(posedge clk_sys_in);
    end
    instr_valid_in <= 1'b0;
    #1 chk(acc_out, 4'h3);
    rdc(4'h8, v + 8'h03);
    rdc(4'h7, 8'h43);
    wr(4'h7, 8'hFF);
    rdc(4'h7, 8'h43);
    rdc(4'hF, 8'h00);
    $display("back to back test done");
    ex(8'h01, 2'h1);
    ex(8'h0A, 2'h2);
    ex(8'h05, 2'h3);
    chk(branch_target_address_out, 12'h1A5);
    rdc(4'h9, 8'hA5);
    exa(8'h42, 4'h2);
    chk({bit_select_out, bit_mask_out}, 6'h24);
    exa(8'h00, 4'h2);
    chk({instr_class_out, load_done_out}, 4'hE);
    chk({bit_select_out, bit_mask_out}, 6'h01);
    $display("field test done");
    finish_test;
  end
endmodule // tb

bind nlid_core nlid_core_monitor i_nlid_core_monitor (.clk_sys_in, .rst_in, .instr_in, .instr_valid_in,
  .field_sel_in, .port_data_in, .mem_data_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .acc_out,
  .zero_flag_out, .carry_flag_out, .alt_valid_out, .branch_target_address_out, .bit_mask_out,
  .instr_class_out, .load_done_out);
